/* File: hdl/vcr_regs.sv */
// Channel-0 resource register bank behind an AXI4-Lite slave
//
// Operation
// R1 - Arbitration capability reads fixed 09h
// R2 - No time-based scheme on this channel
// R3 - Bit 14 reads zero, read-only
// R4 - Bit 15 snoop reject reads zero
// R5 - Time slots field, loadable default 7Fh
// R6 - Table offset reads 04h sixteen-byte units
// R7 - Writable traffic class map, default FFh
// R8 - Writing load bit applies table
// R9 - Load bit always reads zero
// R10 - Select keeps 000b/011b, else default
// R11 - Channel identifier read-only 000b
// R12 - Bit 31 enables channel, resets one
// R13 - Table status sets on table write
// R14 - Table status clears when load done
// R15 - Negotiation pending reads one while negotiating
// R16 - Pending clears when negotiation completes
// R17 - Reserved bits read zero, ignore writes
//
// Decided for this implementation: the AXI4-Lite register port.
`default_nettype none
module vcr_regs
    import vcr_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic awvalid,
    output logic awready,
    input wire logic [11:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [11:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Autoload of defaults, same clock domain
    input wire logic autoload_valid,
    input wire logic [7:0] autoload_tc_map,
    input wire logic [6:0] autoload_slots,
    // Arbiter side, same clock domain
    input wire logic table_entry_written,
    input wire logic table_load_done,
    input wire logic negotiation_start,
    input wire logic negotiation_done,
    output logic table_load_pulse,
    output logic [7:0] traffic_class_map,
    output logic [2:0] port_arb_select,
    output logic channel_enable
);
    // Bus state
    logic aw_held_q, aw_held_d;
    logic w_held_q, w_held_d;
    logic [11:0] aw_addr_q, aw_addr_d;
    logic [31:0] w_data_q, w_data_d;
    logic [3:0] w_strb_q, w_strb_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    logic awready_q, awready_d;
    logic wready_q, wready_d;
    logic arready_q, arready_d;
    // Register state
    logic [7:0] tc_map_q, tc_map_d;
    logic [6:0] slots_q, slots_d;
    logic [2:0] sel_q, sel_d;
    logic en_q, en_d;
    logic load_q, load_d;
    logic tbl_sts_q, tbl_sts_d;
    logic neg_q, neg_d;
    logic do_write;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;

    // Word decode, shared by read and write paths
    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = (a[11:2] == VCR_CAP_OFF[11:2]) || (a[11:2] == VCR_CTL_OFF[11:2])
            || (a[11:2] == VCR_STS_OFF[11:2]);
    endfunction

    // Read view of the three words
    function automatic logic [31:0] read_word(input logic [11:0] a, input logic [7:0] tcm,
        input logic [6:0] sl, input logic [2:0] sl3, input logic e, input logic ts, input logic ng);
        logic [31:0] v;
        v = 32'h0;
        if (a[11:2] == VCR_CAP_OFF[11:2]) begin
            // R1 fixed capability; R2 no time-based bit in it
            v[7:0] = VCR_ARB_CAP_RST;
            // R3 advanced switching zero
            v[VCR_ADV_SW_BIT] = 1'b0;
            // R4 snoop reject zero
            v[VCR_SNOOP_BIT] = 1'b0;
            // R5 time slots field
            v[VCR_SLOTS_LSB +: 7] = sl;
            // R6 table offset field
            v[VCR_TBL_OFS_LSB +: 8] = VCR_TBL_OFS_RST;
        end else if (a[11:2] == VCR_CTL_OFF[11:2]) begin
            v[7:0] = tcm;
            // R9 load bit reads zero
            v[VCR_LOAD_BIT] = 1'b0;
            v[VCR_SEL_LSB +: 3] = sl3;
            // R11 identifier constant
            v[VCR_ID_LSB +: 3] = VCR_ID_RST;
            v[VCR_EN_BIT] = e;
        end else if (a[11:2] == VCR_STS_OFF[11:2]) begin
            v[VCR_TBL_STS_BIT] = ts;
            v[VCR_NEG_BIT] = ng;
        end
        // R17 everything else stays zero
        read_word = v;
    endfunction

    // Write path: capture address and data in either order
    always_comb begin
        aw_held_d = aw_held_q;
        w_held_d = w_held_q;
        aw_addr_d = aw_addr_q;
        w_data_d = w_data_q;
        w_strb_d = w_strb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        wr_addr = aw_held_q ? aw_addr_q : awaddr;
        wr_data = w_held_q ? w_data_q : wdata;
        wr_strb = w_held_q ? w_strb_q : wstrb;
        do_write = 1'b0;
        if (awvalid && awready) begin
            aw_held_d = 1'b1;
            aw_addr_d = awaddr;
        end
        if (wvalid && wready) begin
            w_held_d = 1'b1;
            w_data_d = wdata;
            w_strb_d = wstrb;
        end
        if (bvalid_q && bready) begin
            bvalid_d = 1'b0;
        end
        // Both halves present and no response pending
        if ((aw_held_q || (awvalid && awready)) && (w_held_q || (wvalid && wready)) && !bvalid_q) begin
            do_write = 1'b1;
            aw_held_d = 1'b0;
            w_held_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = is_mapped(wr_addr) ? VCR_RESP_OKAY : VCR_RESP_SLVERR;
        end
        // Ready only while the slot stays empty, so a held beat is never overwritten
        awready_d = !aw_held_d && !bvalid_d;
        wready_d = !w_held_d && !bvalid_d;
    end

    // Write path registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_addr_q <= 12'h0;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= VCR_RESP_OKAY;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
        end else begin
            aw_held_q <= aw_held_d;
            w_held_q <= w_held_d;
            aw_addr_q <= aw_addr_d;
            w_data_q <= w_data_d;
            w_strb_q <= w_strb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
        end
    end

    // Readies from flops, loaded from the next state
    assign awready = awready_q;
    assign wready = wready_q;

    // Read path: one outstanding read, answered next cycle
    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (rvalid_q && rready) begin
            rvalid_d = 1'b0;
        end
        if (arvalid && !rvalid_q) begin
            rvalid_d = 1'b1;
            rdata_d = read_word(araddr, tc_map_q, slots_q, sel_q, en_q, tbl_sts_q, neg_q);
            rresp_d = is_mapped(araddr) ? VCR_RESP_OKAY : VCR_RESP_SLVERR;
        end
        // Refuse a new read while an answer stands
        arready_d = !rvalid_d;
    end

    // Read path registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= VCR_RESP_OKAY;
            arready_q <= 1'b1;
        end else begin
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            arready_q <= arready_d;
        end
    end

    assign arready = arready_q;

    // Register contents and hardware-driven flags
    always_comb begin
        tc_map_d = tc_map_q;
        slots_d = slots_q;
        sel_d = sel_q;
        en_d = en_q;
        load_d = 1'b0;
        tbl_sts_d = tbl_sts_q;
        neg_d = neg_q;
        // R5 autoload replaces time slot default
        if (autoload_valid) begin
            slots_d = autoload_slots;
        end
        // R7 autoload replaces map default
        if (autoload_valid) begin
            tc_map_d = autoload_tc_map;
        end
        if (do_write && (wr_addr[11:2] == VCR_CTL_OFF[11:2])) begin
            // R7 map written via byte lane 0
            if (wr_strb[0]) begin
                tc_map_d = wr_data[7:0];
            end
            if (wr_strb[2]) begin
                // R8 load request pulse
                load_d = wr_data[VCR_LOAD_BIT];
                // R10 unsupported codes fall back
                if (wr_data[VCR_SEL_LSB +: 3] == VCR_SEL_WRR) begin
                    sel_d = VCR_SEL_WRR;
                end else begin
                    sel_d = VCR_SEL_DEFAULT;
                end
            end
            // R12 channel enable bit
            if (wr_strb[3]) begin
                en_d = wr_data[VCR_EN_BIT];
            end
        end
        // R14 clear on load completion
        if (table_load_done) begin
            tbl_sts_d = 1'b0;
        end
        // R13 set wins over clear
        if (table_entry_written) begin
            tbl_sts_d = 1'b1;
        end
        // R16 clear when negotiation completes
        if (negotiation_done) begin
            neg_d = 1'b0;
        end
        // R15 pending while negotiating
        if (negotiation_start) begin
            neg_d = 1'b1;
        end
    end

    // Register contents flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tc_map_q <= VCR_TC_MAP_RST;
            slots_q <= VCR_SLOTS_RST;
            sel_q <= VCR_SEL_DEFAULT;
            en_q <= VCR_EN_RST;
            load_q <= 1'b0;
            tbl_sts_q <= 1'b0;
            neg_q <= 1'b0;
        end else begin
            tc_map_q <= tc_map_d;
            slots_q <= slots_d;
            sel_q <= sel_d;
            en_q <= en_d;
            load_q <= load_d;
            tbl_sts_q <= tbl_sts_d;
            neg_q <= neg_d;
        end
    end

    // Outputs straight from flops
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign table_load_pulse = load_q;
    assign traffic_class_map = tc_map_q;
    assign port_arb_select = sel_q;
    assign channel_enable = en_q;
endmodule
`default_nettype wire

/* File: shared/vcr_pkg.sv */
// Offsets, field positions and reset values for the channel-0 resource registers
`default_nettype none
package vcr_pkg;
    // Register byte offsets
    localparam logic [11:0] VCR_CAP_OFF = 12'h150;
    localparam logic [11:0] VCR_CTL_OFF = 12'h154;
    localparam logic [11:0] VCR_STS_OFF = 12'h158;
    // Capability fields
    localparam logic [7:0] VCR_ARB_CAP_RST = 8'h09;
    localparam logic [6:0] VCR_SLOTS_RST = 7'h7f;
    localparam logic [7:0] VCR_TBL_OFS_RST = 8'h04;
    localparam int VCR_ADV_SW_BIT = 14;
    localparam int VCR_SNOOP_BIT = 15;
    localparam int VCR_SLOTS_LSB = 16;
    localparam int VCR_TBL_OFS_LSB = 24;
    // Control fields
    localparam logic [7:0] VCR_TC_MAP_RST = 8'hff;
    localparam int VCR_LOAD_BIT = 16;
    localparam int VCR_SEL_LSB = 17;
    localparam int VCR_ID_LSB = 24;
    localparam int VCR_EN_BIT = 31;
    localparam logic VCR_EN_RST = 1'b1;
    localparam logic [2:0] VCR_SEL_DEFAULT = 3'h0;
    localparam logic [2:0] VCR_SEL_WRR = 3'h3;
    localparam logic [2:0] VCR_ID_RST = 3'h0;
    // Status fields
    localparam int VCR_TBL_STS_BIT = 16;
    localparam int VCR_NEG_BIT = 17;
    // AXI responses
    localparam logic [1:0] VCR_RESP_OKAY = 2'h0;
    localparam logic [1:0] VCR_RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

/* File: sim/vcr_regs_properties.sv */
// Concurrent checks on the channel-0 resource register bank ports
`default_nettype none
module vcr_regs_properties
    import vcr_pkg::*;
(
    // Clock, reset, read bus and write response valid
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [11:0] araddr,
    input wire logic [31:0] rdata,
    input wire logic bvalid,
    // Autoload and arbiter side
    input wire logic autoload_valid,
    input wire logic table_load_pulse,
    input wire logic [7:0] traffic_class_map,
    input wire logic [2:0] port_arb_select,
    input wire logic channel_enable
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Read accepted at this edge, per word
    wire rc = arvalid && arready && araddr[11:2] == 10'h054;
    wire rl = arvalid && arready && araddr[11:2] == 10'h055;
    wire rs = arvalid && arready && araddr[11:2] == 10'h056;
    AST_SEL_CODE: assert property (port_arb_select == VCR_SEL_DEFAULT || port_arb_select == VCR_SEL_WRR)
        else $error("select holds an unsupported code");
    AST_CAP_READ: assert property (rc |=> rdata[15:0] == 16'h0009 && rdata[31:23] == 9'h008)
        else $error("capability word fixed fields wrong");
    AST_CTL_READ: assert property (rl |=> rdata == {$past(channel_enable), 11'h0, $past(port_arb_select),
        1'b0, 8'h0, $past(traffic_class_map)}) else $error("control word readback wrong");
    AST_STS_READ: assert property (rs |=> rdata[15:0] == 16'h0 && rdata[31:18] == 14'h0)
        else $error("status reserved bits not zero");
    AST_LOAD_ONE: assert property (table_load_pulse |=> !table_load_pulse)
        else $error("load pulse longer than one cycle");
    // Outputs move only with a completed write or an autoload
    AST_EN_WRITE: assert property ($changed(channel_enable) |-> $rose(bvalid))
        else $error("enable changed without a write");
    AST_SEL_WRITE: assert property ($changed(port_arb_select) |-> $rose(bvalid))
        else $error("select changed without a write");
    AST_MAP_CAUSE: assert property ($changed(traffic_class_map) |-> $rose(bvalid) || $past(autoload_valid))
        else $error("class map changed without cause");
endmodule
bind vcr_regs vcr_regs_properties vcr_regs_properties_inst (.aclk, .aresetn, .arvalid, .arready, .araddr, .rdata,
    .bvalid, .autoload_valid, .table_load_pulse, .traffic_class_map, .port_arb_select, .channel_enable);
`default_nettype wire

/* File: sim/vcr_regs_bench.sv */
// Self-checking bench for the channel-0 resource register bank
`default_nettype none
module vcr_regs_bench
    import vcr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, autoload_valid = 0;
    logic awready, wready, bvalid, arready, rvalid, table_load_pulse, channel_enable, en = 1;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, seed = 32'h611b, d, got;
    logic [3:0] wstrb = 0, ev = 0, s;
    logic [7:0] autoload_tc_map = 0, traffic_class_map, map = 8'hff;
    logic [6:0] autoload_slots = 0;
    logic [2:0] port_arb_select, sel = 0;
    logic [1:0] bresp, rresp;
    int n_fail = 0, comparisons = 0, cyc = 0, npul = 0, epul = 0;
    vcr_regs vcr_regs_inst (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .autoload_valid(autoload_valid), .autoload_tc_map(autoload_tc_map),
        .autoload_slots(autoload_slots), .table_entry_written(ev[0]), .table_load_done(ev[1]),
        .negotiation_start(ev[2]), .negotiation_done(ev[3]), .table_load_pulse(table_load_pulse),
        .traffic_class_map(traffic_class_map), .port_arb_select(port_arb_select),
        .channel_enable(channel_enable));
    // Clock
    initial forever #2.5 aclk = ~aclk;
    // Cycle ceiling and load pulse count
    always @(posedge aclk) begin
        cyc++;
        if (table_load_pulse === 1'b1) npul++;
        if (cyc == 5000) begin
            n_fail++;
            give_verdict();
        end
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] cap_exp(logic [6:0] sl);
        return {8'h04, 1'b0, sl, 16'h0009};
    endfunction
    function automatic logic [31:0] ctl_exp();
        return {en, 11'h0, sel, 1'b0, 8'h0, map};
    endfunction
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Readies sampled at the falling edge, clear of the design's own updates
    task automatic wr(logic [11:0] a, logic [31:0] dv, logic [3:0] st, logic [1:0] er);
        logic ad, wd;
        ad = 0;
        wd = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= dv;
        wstrb <= st;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!(ad && wd)) begin
            @(negedge aclk);
            ad |= awvalid && awready;
            wd |= wvalid && wready;
            @(posedge aclk);
            if (ad) awvalid <= 0;
            if (wd) wvalid <= 0;
        end
        do @(negedge aclk); while (bvalid !== 1'b1);
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        @(posedge aclk);
        bready <= 0;
    endtask
    task automatic rd(logic [11:0] a, logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(negedge aclk); while (arready !== 1'b1);
        @(posedge aclk);
        arvalid <= 0;
        do @(negedge aclk); while (rvalid !== 1'b1);
        got = rdata;
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        @(posedge aclk);
        rready <= 0;
    endtask
    task automatic ev_pulse(logic [3:0] m);
        @(posedge aclk);
        ev <= m;
        @(posedge aclk);
        ev <= 4'h0;
    endtask
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        // Idle bus and register outputs right after reset
        @(negedge aclk);
        chk("idle", {14'h0, 5'h1c, VCR_TC_MAP_RST, VCR_SEL_DEFAULT, VCR_EN_RST, 1'b0}, {14'h0, awready, wready,
            arready, bvalid, rvalid, traffic_class_map, port_arb_select, channel_enable, table_load_pulse});
        // Reset values of the three words
        rd(12'h150, 2'h0);
        chk("cap", cap_exp(7'h7f), got);
        rd(12'h154, 2'h0);
        chk("ctl", ctl_exp(), got);
        rd(12'h158, 2'h0);
        chk("sts", 32'h0, got);
        // Random control writes and strobes, every select code
        for (int i = 0; i < 24; i++) begin
            d = xs();
            got = xs();
            s = (i == 0) ? 4'hf : got[3:0];
            d[19:17] = i[2:0];
            wr(12'h154, d, s, 2'h0);
            if (s[0]) map = d[7:0];
            if (s[2]) sel = (d[19:17] == 3'h3) ? 3'h3 : 3'h0;
            if (s[2]) epul += d[16];
            if (s[3]) en = d[31];
            rd(12'h154, 2'h0);
            chk("ctl", ctl_exp(), got);
            chk("pins", {20'h0, en, sel, map}, {20'h0, channel_enable, port_arb_select, traffic_class_map});
            chk("loads", 32'(epul), 32'(npul));
        end
        // Read-only words and an unmapped hole
        wr(12'h150, 32'h0, 4'hf, 2'h0);
        wr(12'h158, 32'hffffffff, 4'hf, 2'h0);
        wr(12'h15c, 32'hffffffff, 4'hf, 2'h2);
        rd(12'h150, 2'h0);
        chk("cap_ro", cap_exp(7'h7f), got);
        rd(12'h15c, 2'h2);
        chk("hole", 32'h0, got);
        rd(12'h154, 2'h0);
        chk("ctl_kept", ctl_exp(), got);
        // Table and negotiation flags set, then cleared
        for (int b = 0; b < 4; b++) begin
            ev_pulse(4'h1 << b);
            rd(12'h158, 2'h0);
            chk("sts", {14'h0, b == 2, b == 0, 16'h0}, got);
        end
        // Set and clear in one cycle: the set wins
        ev_pulse(4'h3);
        rd(12'h158, 2'h0);
        chk("sts_set_wins", 32'h0001_0000, got);
        ev_pulse(4'hc);
        rd(12'h158, 2'h0);
        chk("sts_start_wins", 32'h0003_0000, got);
        ev_pulse(4'ha);
        rd(12'h158, 2'h0);
        chk("sts_cleared", 32'h0, got);
        // Autoload replaces map and slot defaults
        d = xs();
        @(posedge aclk);
        autoload_tc_map <= d[7:0];
        autoload_slots <= d[14:8];
        autoload_valid <= 1;
        @(posedge aclk);
        autoload_valid <= 0;
        map = d[7:0];
        rd(12'h150, 2'h0);
        chk("cap_load", cap_exp(d[14:8]), got);
        rd(12'h154, 2'h0);
        chk("ctl_load", ctl_exp(), got);
        give_verdict();
    end
endmodule
`default_nettype wire
